// ===== drs_pkg.sv
// Shared constants and types for the DRAM refresh and access sequencer
package drs_pkg;
   localparam logic [2:0] MODE_FORCED_REFRESH = 3'h0;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned REF_PERIOD_NS = 80;
   localparam int unsigned REF_ACCESS_PERIODS = 4;
   localparam int unsigned ACCESS_NS = REF_PERIOD_NS * REF_ACCESS_PERIODS;
   localparam int unsigned GUARD_CYCLES = 1;
   localparam int unsigned BANK_GUARD_CYCLES = 2;
   localparam int unsigned REFRESH_CYCLES = 3;
   localparam int unsigned ACCESS_CYCLES = REF_ACCESS_PERIODS;
   localparam logic [3:0] LANES_NONE = 4'h0;

   typedef enum logic [2:0] {
      DRS_IDLE = 3'b000,
      DRS_ACCESS = 3'b001,
      DRS_REFRESH = 3'b010,
      DRS_GUARD = 3'b011,
      DRS_DONE = 3'b100
   } drs_state_t;

   typedef struct packed {
      logic chip_select_n;
      logic address_strobe_n;
      logic data_strobe_n;
      logic read_write;
      logic [1:0] size_lanes;
      logic [1:0] bank_addr;
   } drs_cpu_t;
endpackage

// ===== drs_sequencer.sv
// DRAM refresh and access sequencer between a 32-bit processor bus and a DRAM controller
//
// Design decisions made here: the plain strobed port and the address map.
module drs_sequencer
   import drs_pkg::*;
#(
   parameter bit VARIANT_CAS = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire drs_cpu_t cpu,
   input wire logic refresh_request_line_n,
   input wire logic zero_wait_select_n,
   input wire logic interleave_enable,
   output logic row_strobe_request_n,
   output logic refresh_command_n,
   output logic [2:0] mode_select,
   output logic cycle_acknowledge_n,
   output logic [3:0] byte_write_enable_n,
   output logic [3:0] byte_column_strobe_n,
   output logic previous_bank_flag,
   output logic precharge_guard_n
);
   drs_state_t state_reg, state_next;
   logic [2:0] count_reg, count_next;
   logic refresh_req_reg;
   logic [1:0] last_bank_reg;
   logic bank_valid_reg;
   logic access_req;
   logic same_bank;
   logic zero_wait;
   logic [3:0] lane_mask;
   logic [2:0] access_len;
   logic [2:0] refresh_len;
   logic [2:0] guard_len;

   assign zero_wait = ~zero_wait_select_n;
   // Start only when select and address strobe are true together
   assign access_req = ~cpu.chip_select_n & ~cpu.address_strobe_n;
   // Bank check can be switched off so the bank input is free for other use
   assign same_bank = interleave_enable & bank_valid_reg
      & (cpu.bank_addr == last_bank_reg) & ~VARIANT_CAS;
   assign access_len = zero_wait ? 3'(ACCESS_CYCLES - 1) : 3'(ACCESS_CYCLES);
   assign refresh_len = zero_wait ? 3'(REFRESH_CYCLES - 1) : 3'(REFRESH_CYCLES);
   assign guard_len = same_bank ? 3'(BANK_GUARD_CYCLES) : 3'(GUARD_CYCLES);

   always_comb begin
      // Lanes follow the transfer size; a long word always uses all four lanes
      case (cpu.size_lanes)
         2'h1: lane_mask = 4'h8;
         2'h2: lane_mask = 4'hc;
         2'h3: lane_mask = 4'he;
         default: lane_mask = 4'hf;
      endcase
   end

   // Refresh request sampled on the clock; arbitration never sees the raw pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refresh_req_reg <= 1'b0;
      end else if (clk_en) begin
         refresh_req_reg <= ~refresh_request_line_n;
      end
   end

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         DRS_IDLE: begin
            // Refresh wins only when no access is running; no hidden refresh
            if (refresh_req_reg) begin
               state_next = DRS_REFRESH;
               count_next = refresh_len;
            end else if (access_req && !same_bank) begin
               state_next = DRS_ACCESS;
               count_next = access_len;
            end else if (access_req) begin
               state_next = DRS_GUARD;
               count_next = guard_len;
            end
         end
         DRS_ACCESS: begin
            if (count_reg <= 3'h1 || cpu.address_strobe_n) begin
               state_next = DRS_DONE;
            end else begin
               count_next = count_reg - 3'h1;
            end
         end
         DRS_REFRESH: begin
            if (count_reg <= 3'h1) begin
               state_next = DRS_GUARD;
               count_next = 3'(GUARD_CYCLES);
            end else begin
               count_next = count_reg - 3'h1;
            end
         end
         DRS_GUARD: begin
            if (count_reg <= 3'h1) begin
               state_next = DRS_IDLE;
            end else begin
               count_next = count_reg - 3'h1;
            end
         end
         DRS_DONE: begin
            // Wait for the processor to drop the strobe before rearming
            if (cpu.address_strobe_n) begin
               state_next = DRS_IDLE;
            end
         end
         default: state_next = DRS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= DRS_IDLE;
         count_reg <= 3'h0;
      end else if (clk_en) begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_bank_reg <= 2'h0;
         bank_valid_reg <= 1'b0;
         previous_bank_flag <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == DRS_IDLE && state_next == DRS_ACCESS) begin
            last_bank_reg <= cpu.bank_addr;
            bank_valid_reg <= 1'b1;
            previous_bank_flag <= cpu.bank_addr[0];
         end else if (state_next == DRS_REFRESH || state_next == DRS_GUARD) begin
            // Guard already gives the precharge; clearing stops a guard loop
            bank_valid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         row_strobe_request_n <= 1'b1;
         refresh_command_n <= 1'b1;
         mode_select <= 3'h7;
         precharge_guard_n <= 1'b1;
      end else if (clk_en) begin
         // Variant two drops the request a cycle early to win precharge time
         if (VARIANT_CAS && state_next == DRS_ACCESS && count_next <= 3'h1) begin
            row_strobe_request_n <= 1'b1;
         end else begin
            row_strobe_request_n <= ~(state_next == DRS_ACCESS
               || state_next == DRS_REFRESH);
         end
         refresh_command_n <= ~(state_next == DRS_REFRESH);
         mode_select <= (state_next == DRS_REFRESH) ? MODE_FORCED_REFRESH : 3'h7;
         precharge_guard_n <= ~(state_next == DRS_GUARD);
      end
   end

   // Acknowledge held back through guard, refresh and the wait period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cycle_acknowledge_n <= 1'b1;
      end else if (clk_en) begin
         cycle_acknowledge_n <= ~((state_next == DRS_ACCESS && count_next <= 3'h2)
            || (state_next == DRS_DONE && !cpu.address_strobe_n));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         byte_write_enable_n <= 4'hf;
         byte_column_strobe_n <= 4'hf;
      end else if (clk_en) begin
         byte_write_enable_n <= 4'hf;
         byte_column_strobe_n <= 4'hf;
         if (state_next == DRS_ACCESS && !cpu.data_strobe_n) begin
            if (!VARIANT_CAS && !cpu.read_write) begin
               byte_write_enable_n <= ~lane_mask;
            end
            if (VARIANT_CAS) begin
               byte_column_strobe_n <= cpu.read_write ? LANES_NONE : ~lane_mask;
            end
         end
      end
   end
endmodule

// ===== drs_sequencer_assertions.sv
// Checker for the DRAM refresh and access sequencer
module drs_sequencer_chk
   import drs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire drs_cpu_t cpu,
   input wire logic refresh_request_line_n,
   input wire logic zero_wait_select_n,
   input wire logic row_strobe_request_n,
   input wire logic refresh_command_n,
   input wire logic [2:0] mode_select,
   input wire logic cycle_acknowledge_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_start_cause: assert property ($fell(row_strobe_request_n) |-> !refresh_command_n ||
      $past(!cpu.chip_select_n && !cpu.address_strobe_n)) else $error("row request without cause");
   chk_mode_refresh: assert property (
      (mode_select == MODE_FORCED_REFRESH) == !refresh_command_n) else $error("mode select wrong");
   chk_no_hidden: assert property (!refresh_command_n |-> cycle_acknowledge_n)
      else $error("acknowledge during refresh");
   chk_ack_release: assert property (
      !cycle_acknowledge_n && cpu.address_strobe_n |=> cycle_acknowledge_n) else $error("ack stuck");
   chk_ack_latency: assert property (
      $fell(row_strobe_request_n) && refresh_command_n && zero_wait_select_n |->
      cycle_acknowledge_n [*2] ##1 !cycle_acknowledge_n) else $error("ack latency wrong");
   chk_ref_sync: assert property ($fell(refresh_command_n) |-> $past(!refresh_request_line_n))
      else $error("refresh without request");
   chk_ref_len: assert property ($fell(refresh_command_n) && zero_wait_select_n |->
      !refresh_command_n [*3] ##1 refresh_command_n) else $error("refresh length wrong");
   // Guard keeps a full period between refresh release and the next row request
   chk_guard_gap: assert property ($rose(refresh_command_n) |=> row_strobe_request_n)
      else $error("row request inside guard");
   chk_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
      row_strobe_request_n && refresh_command_n && cycle_acknowledge_n) else $error("not idle");
   cover property ($fell(refresh_command_n));
   cover property ($fell(cycle_acknowledge_n));
   cover property (!zero_wait_select_n && $fell(cycle_acknowledge_n));
endmodule
bind drs_sequencer drs_sequencer_chk u_chk (.clk, .rst_n, .cpu, .refresh_request_line_n,
   .zero_wait_select_n, .row_strobe_request_n, .refresh_command_n, .mode_select,
   .cycle_acknowledge_n);

// ===== drs_ctrl_model.sv
// Model of the DRAM controller's refresh request line
module drs_ctrl_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic refresh_period_clock,
   input wire logic refresh_command_n,
   output logic refresh_request_line_n
);
   always_ff @(posedge clk) begin
      if (!rst_n || !refresh_command_n) begin
         refresh_request_line_n <= 1'b1;
      end else if ($fell(refresh_period_clock)) begin
         refresh_request_line_n <= 1'b0;
      end
   end
endmodule

// ===== drs_sequencer_tb.sv
// Self-checking bench for the DRAM refresh and access sequencer
module drs_sequencer_tb import drs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, zw_n, ilv, pclk, row_n, ref_n, ack_n, req_n, flag;
   drs_cpu_t cpu;
   logic [2:0] mode;
   logic [3:0] we_n, we_s;
   int bad_count, checks_done, n;
   // Rows: read/write, size, bank, expected write enables
   localparam logic [8:0] ROWS [5] = '{9'h10f, 9'h010, 9'h067, 9'h0b3, 9'h0c1};
   drs_sequencer #(.VARIANT_CAS(1'b0)) u_dut (.clk, .rst_n, .clk_en(1'b1), .cpu,
      .refresh_request_line_n(req_n), .zero_wait_select_n(zw_n), .interleave_enable(ilv),
      .row_strobe_request_n(row_n), .refresh_command_n(ref_n), .mode_select(mode),
      .cycle_acknowledge_n(ack_n), .byte_write_enable_n(we_n), .byte_column_strobe_n(),
      .previous_bank_flag(flag), .precharge_guard_n());
   drs_ctrl_model u_ctl (.clk, .rst_n, .refresh_period_clock(pclk), .refresh_command_n(ref_n),
      .refresh_request_line_n(req_n));
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Holds the strobes until acknowledge, as the processor would
   task automatic acc(input logic [4:0] a, input bit kick);
      @(posedge clk);
      cpu <= {3'h0, a};
      if (kick) pclk <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ack_n !== 1'b0 && n < 40);
      we_s = we_n;
      @(posedge clk);
      cpu <= {3'h7, a};
      pclk <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      cpu = 8'hff;
      zw_n = 1'b1;
      ilv = 1'b0;
      pclk = 1'b1;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         acc(ROWS[i][8:4], 1'b0);
         check("access length", 4'(n), 4'(ACCESS_CYCLES));
         check("write enables", we_s, ROWS[i][3:0]);
         check("bank flag", {3'h0, flag}, {3'h0, ROWS[i][4]});
      end
      $display("test table done");
      zw_n <= 1'b0;
      acc(5'h10, 1'b0);
      check("zero wait length", 4'(n), 4'(ACCESS_CYCLES - 1));
      zw_n <= 1'b1;
      ilv <= 1'b1;
      acc(5'h00, 1'b0);
      acc(5'h00, 1'b0);
      check("same bank delayed", 4'(n > ACCESS_CYCLES), 4'h1);
      ilv <= 1'b0;
      $display("test waits done");
      pclk <= 1'b0;
      n = 0;
      while (ref_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("idle refresh", {3'h0, ref_n}, 4'h0);
      acc(5'h12, 1'b0);
      check("access in refresh waits", 4'(n > ACCESS_CYCLES), 4'h1);
      acc(5'h11, 1'b1);
      check("access before refresh", 4'(n), 4'(ACCESS_CYCLES));
      n = 0;
      while (ref_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("deferred refresh", {3'h0, ref_n}, 4'h0);
      $display("test refresh done");
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check("reset outputs", {row_n, ref_n, ack_n, flag}, 4'he);
      check("idle mode", {1'b0, mode}, 4'h7);
      $display("test reset done");
      results();
   end
endmodule
